// *** hdl/tpm_pkg.sv ***
// constants shared by the three-phase pwm block
package tpm_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TPM_OFS_CTRL     = 8'h00;
  localparam logic [7:0] TPM_OFS_CARRIER  = 8'h04;
  localparam logic [7:0] TPM_OFS_DEADTIME = 8'h08;
  localparam logic [7:0] TPM_OFS_WU       = 8'h0C;
  localparam logic [7:0] TPM_OFS_WV       = 8'h10;
  localparam logic [7:0] TPM_OFS_WW       = 8'h14;
  localparam logic [7:0] TPM_OFS_WU2      = 8'h18;
  localparam logic [7:0] TPM_OFS_WV2      = 8'h1C;
  localparam logic [7:0] TPM_OFS_WW2      = 8'h20;
  localparam logic [7:0] TPM_OFS_PINS     = 8'h24;
  localparam logic [7:0] TPM_OFS_STATUS   = 8'h28;
  localparam logic [7:0] TPM_OFS_COUNT    = 8'h2C;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int TPM_B_FEN    = 0;
  localparam int TPM_B_SAW    = 1;
  localparam int TPM_B_TWO    = 2;
  localparam int TPM_B_ACTH   = 3;
  localparam int TPM_B_CDIS   = 4;
  localparam int TPM_B_DTOFF  = 5;
  localparam int TPM_B_HIZ    = 6;
  localparam int TPM_B_RSEL   = 7;
  localparam int TPM_B_CSEL   = 8;
  localparam int TPM_B_DSEL   = 11;
  localparam int TPM_B_IVL    = 16;
  localparam int TPM_B_RUN    = 20;
  localparam logic [31:0] TPM_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TPM_CTRL_MSK = 32'h001F_1FFF;
  // ----------------------------------------------------------------
  // count source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TPM_SRC_F1   = 3'h0;
  localparam logic [2:0] TPM_SRC_F2   = 3'h1;
  localparam logic [2:0] TPM_SRC_F8   = 3'h2;
  localparam logic [2:0] TPM_SRC_F32  = 3'h3;
  localparam logic [2:0] TPM_SRC_SC32 = 3'h4;
  localparam logic [1:0] TPM_DSRC_F1   = 2'h0;
  localparam logic [1:0] TPM_DSRC_F2   = 2'h1;
  localparam logic [1:0] TPM_DSRC_F1D2 = 2'h2;
  localparam logic [1:0] TPM_DSRC_F2D2 = 2'h3;
  // ----------------------------------------------------------------
  // carrier direction
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TPM_CAR_UP   = 2'b01,
    TPM_CAR_DOWN = 2'b10
  } tpm_dir_type;
endpackage

// *** hdl/tpm_dt_if.sv ***
// carrier between the waveform core and the dead-time stage
`timescale 1ns/10ps
interface tpm_dt_if;
  logic [2:0] raw;
  logic       tick;
  logic [7:0] setting;
  logic       bypass;
  logic [2:0] pos;
  logic [2:0] neg;
  modport core (output raw, tick, setting, bypass, input pos, neg);
  modport dt   (input raw, tick, setting, bypass, output pos, neg);
endinterface

// *** hdl/tpm_dead_time.sv ***
// three per-phase dead-time down-counters sharing one reload value
`timescale 1ns/10ps
module tpm_dead_time
  import tpm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  tpm_dt_if.dt      b
);
  typedef struct packed {
    logic [2:0][7:0] cnt;
    logic [2:0]      last;
    logic [2:0]      pos;
    logic [2:0]      neg;
  } tpm_dt_state_type;

  tpm_dt_state_type s_r;
  tpm_dt_state_type s_nxt;

  // ----------------------------------------------------------------
  // per-phase counters
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < 3; i++) begin
      if (b.bypass) begin
        s_nxt.cnt[i]  = 8'h00;
        s_nxt.last[i] = b.raw[i];
        s_nxt.pos[i]  = b.raw[i];
        s_nxt.neg[i]  = ~b.raw[i];
      end else if (b.raw[i] != s_r.last[i]) begin
        s_nxt.last[i] = b.raw[i];
        s_nxt.cnt[i]  = b.setting;
        s_nxt.pos[i]  = 1'b0;
        s_nxt.neg[i]  = 1'b0;
      end else if (s_r.cnt[i] != 8'h00) begin
        if (b.tick) begin
          s_nxt.cnt[i] = s_r.cnt[i] - 8'h01;
          // on at the last tick, so the gap is p ticks, not p+1
          if (s_r.cnt[i] == 8'h01) begin
            s_nxt.pos[i] = s_r.last[i];
            s_nxt.neg[i] = ~s_r.last[i];
          end
        end
      end else begin
        s_nxt.pos[i] = s_r.last[i];
        s_nxt.neg[i] = ~s_r.last[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign b.pos = s_r.pos;
  assign b.neg = s_r.neg;
endmodule

// *** hdl/tpm_top.sv ***
// three-phase motor pwm generator with apb registers
//
// Contract
// - six drive outputs, positive and negative pin per U, V, W phase.
// - three one-shot phase timers drive U, V and W respectively.
// - one carrier timer sets the carrier period for all phases.
// - triangular carrier period is source period times (m+1) times two.
// - sawtooth carrier period is source period times (m+1).
// - triangular width is source period times n times two.
// - sawtooth width is source period times n.
// - in triangular mode, two-value select gives each phase primary and secondary widths.
// - carrier and phases count on f1, f2, f8, f32 or subclock/32.
// - dead time is p dead-time ticks, or disabled.
// - three 8-bit dead-time counters reload from one shared setting.
// - dead-time source is f1, f2, f1/2 or f2/2.
// - drive active level selectable high or low.
// - any output can be held high or low a whole carrier cycle.
// - positive and negative levels of a phase set independently.
// - optionally block both pins active; always flag both active.
// - carrier pulse every 1 to 15 carrier cycles.
// - function enable turns the shared pin into the shutdown input.
// - shutdown low with high-z cutoff floats all six pins.
// - shutdown low without high-z cutoff returns pins to port control.
// - reload timing select: underflow only, or also at the triangle top.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module tpm_top
  import tpm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int DT_W  = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shutdown_input_n,
  input  wire logic        subclock,
  output logic      [5:0]  drive_out,
  output logic      [5:0]  drive_oe_n,
  output logic             carrier_pulse
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must be 2 to 16");
  end
  if (DT_W < 1 || DT_W > 8) begin : g_bad_dt
    $error("DT_W must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]            ctrl;
    logic [CNT_W-1:0]       car_m;
    logic [DT_W-1:0]        dt_set;
    logic [5:0][CNT_W-1:0]  width;
    logic [5:0][CNT_W-1:0]  shadow;
    logic [5:0]             force_en;
    logic [5:0]             force_lvl;
    logic [5:0]             port_data;
    logic [5:0]             port_dir;
    logic [5:0]             fsh_en;
    logic [5:0]             fsh_lvl;
    logic [2:0]             conc_flag;
    logic                   cut_flag;
    logic                   sd_s1;
    logic                   sd_s2;
    logic                   sc_s1;
    logic                   sc_s2;
    logic                   sc_prev;
    logic [4:0]             div_cnt;
    logic [4:0]             sc_cnt;
    logic [CNT_W-1:0]       car_cnt;
    tpm_dir_type            car_dir;
    logic [3:0]             ivl_cnt;
    logic                   pulse;
    logic [2:0]             raw;
    logic                   dt_tick;
    logic [5:0]             drv;
    logic [5:0]             oe_n;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
  } tpm_state_type;

  tpm_state_type s_r;
  tpm_state_type s_nxt;
  tpm_dt_if      dtb ();

  tpm_dead_time u_dead_time (
    .pclk    (pclk),
    .presetn (presetn),
    .b       (dtb.dt)
  );

  assign dtb.raw     = s_r.raw;
  assign dtb.tick    = s_r.dt_tick;
  assign dtb.setting = 8'(s_r.dt_set);
  assign dtb.bypass  = s_r.ctrl[TPM_B_DTOFF];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic             fen;
  logic             saw;
  logic             two;
  logic             run;
  logic [2:0]       csel;
  logic [1:0]       dsel;
  logic [3:0]       ivl;
  logic             sc_edge;
  logic             tick;
  logic             uf;
  logic             top;
  logic [5:0]       act;
  logic [2:0]       both;
  logic [5:0]       lvl;
  logic             setup;
  logic             wr;
  logic             hit;
  logic [31:0]      rd;

  always_comb begin
    s_nxt   = s_r;
    fen     = s_r.ctrl[TPM_B_FEN];
    saw     = s_r.ctrl[TPM_B_SAW];
    two     = s_r.ctrl[TPM_B_TWO];
    run     = s_r.ctrl[TPM_B_RUN];
    csel    = s_r.ctrl[TPM_B_CSEL +: 3];
    dsel    = s_r.ctrl[TPM_B_DSEL +: 2];
    ivl     = s_r.ctrl[TPM_B_IVL +: 4];
    uf      = 1'b0;
    top     = 1'b0;
    act     = '0;
    both    = '0;
    lvl     = '0;
    rd      = '0;
    hit     = 1'b1;

    // pin inputs pass two flops first
    s_nxt.sd_s1   = shutdown_input_n;
    s_nxt.sd_s2   = s_r.sd_s1;
    s_nxt.sc_s1   = subclock;
    s_nxt.sc_s2   = s_r.sc_s1;
    s_nxt.sc_prev = s_r.sc_s2;
    sc_edge       = s_r.sc_s2 & ~s_r.sc_prev;
    s_nxt.div_cnt = s_r.div_cnt + 5'h01;
    if (sc_edge) begin
      s_nxt.sc_cnt = s_r.sc_cnt + 5'h01;
    end

    unique case (csel)
      TPM_SRC_F1:   tick = 1'b1;
      TPM_SRC_F2:   tick = s_r.div_cnt[0];
      TPM_SRC_F8:   tick = &s_r.div_cnt[2:0];
      TPM_SRC_F32:  tick = &s_r.div_cnt;
      TPM_SRC_SC32: tick = sc_edge & (&s_r.sc_cnt);
      default:      tick = 1'b0;
    endcase

    unique case (dsel)
      TPM_DSRC_F1:   s_nxt.dt_tick = 1'b1;
      TPM_DSRC_F2:   s_nxt.dt_tick = s_r.div_cnt[0];
      TPM_DSRC_F1D2: s_nxt.dt_tick = s_r.div_cnt[0];
      TPM_DSRC_F2D2: s_nxt.dt_tick = &s_r.div_cnt[1:0];
      default:       s_nxt.dt_tick = 1'b0;
    endcase

    if (!run) begin
      s_nxt.car_cnt = saw ? s_r.car_m : '0;
      s_nxt.car_dir = saw ? TPM_CAR_DOWN : TPM_CAR_UP;
    end else if (tick) begin
      if (saw) begin
        s_nxt.car_dir = TPM_CAR_DOWN;
        if (s_r.car_cnt == '0) begin
          s_nxt.car_cnt = s_r.car_m;
          uf            = 1'b1;
        end else begin
          s_nxt.car_cnt = s_r.car_cnt - 1'b1;
        end
      end else begin
        unique case (s_r.car_dir)
          TPM_CAR_UP: begin
            if (s_r.car_cnt >= s_r.car_m) begin
              s_nxt.car_dir = TPM_CAR_DOWN;
              top           = 1'b1;
            end else begin
              s_nxt.car_cnt = s_r.car_cnt + 1'b1;
            end
          end
          TPM_CAR_DOWN: begin
            if (s_r.car_cnt == '0) begin
              s_nxt.car_dir = TPM_CAR_UP;
              uf            = 1'b1;
            end else begin
              s_nxt.car_cnt = s_r.car_cnt - 1'b1;
            end
          end
          default: s_nxt.car_dir = TPM_CAR_UP;
        endcase
      end
    end

    if (!run || uf || (top && s_r.ctrl[TPM_B_RSEL] && !saw)) begin
      s_nxt.shadow = s_r.width;
    end
    // force held for the whole cycle
    if (!run || uf) begin
      s_nxt.fsh_en  = s_r.force_en;
      s_nxt.fsh_lvl = s_r.force_lvl;
    end

    // phase 0 U, 1 V, 2 W
    for (int i = 0; i < 3; i++) begin
      // secondary width on the falling half
      if (two && !saw && s_r.car_dir == TPM_CAR_DOWN) begin
        s_nxt.raw[i] = run & (s_r.car_cnt < s_r.shadow[i+3]);
      end else begin
        s_nxt.raw[i] = run & (s_r.car_cnt < s_r.shadow[i]);
      end
    end

    s_nxt.pulse = 1'b0;
    if (uf) begin
      if (s_r.ivl_cnt == 4'h0) begin
        s_nxt.pulse   = 1'b1;
        s_nxt.ivl_cnt = (ivl == 4'h0) ? 4'h0 : ivl - 4'h1;
      end else begin
        s_nxt.ivl_cnt = s_r.ivl_cnt - 4'h1;
      end
    end

    for (int i = 0; i < 3; i++) begin
      act[2*i]   = dtb.pos[i];
      act[2*i+1] = dtb.neg[i];
    end
    act = (act & ~s_r.fsh_en) | (s_r.fsh_lvl & s_r.fsh_en);
    for (int i = 0; i < 3; i++) begin
      both[i] = act[2*i] & act[2*i+1];
      if (both[i] && s_r.ctrl[TPM_B_CDIS]) begin
        act[2*i]   = 1'b0;
        act[2*i+1] = 1'b0;
      end
    end
    lvl = s_r.ctrl[TPM_B_ACTH] ? act : ~act;

    if (!fen) begin
      s_nxt.drv  = s_r.port_data;
      s_nxt.oe_n = ~s_r.port_dir;
    end else if (!s_r.sd_s2) begin
      if (s_r.ctrl[TPM_B_HIZ]) begin
        s_nxt.drv  = '0;
        s_nxt.oe_n = 6'h3F;
      end else begin
        s_nxt.drv  = s_r.port_data;
        s_nxt.oe_n = ~s_r.port_dir;
      end
    end else begin
      s_nxt.drv  = lvl;
      s_nxt.oe_n = '0;
    end

    // ----------------------------------------------------------------
    // apb slave, no wait state
    // ----------------------------------------------------------------
    setup = psel & ~penable;
    wr    = psel & penable & pwrite & s_r.ready;
    unique case (paddr)
      TPM_OFS_CTRL:     rd = s_r.ctrl;
      TPM_OFS_CARRIER:  rd = 32'(s_r.car_m);
      TPM_OFS_DEADTIME: rd = 32'(s_r.dt_set);
      TPM_OFS_WU:       rd = 32'(s_r.width[0]);
      TPM_OFS_WV:       rd = 32'(s_r.width[1]);
      TPM_OFS_WW:       rd = 32'(s_r.width[2]);
      TPM_OFS_WU2:      rd = 32'(s_r.width[3]);
      TPM_OFS_WV2:      rd = 32'(s_r.width[4]);
      TPM_OFS_WW2:      rd = 32'(s_r.width[5]);
      TPM_OFS_PINS:     rd = {2'h0, s_r.port_dir, 2'h0, s_r.port_data,
                              2'h0, s_r.force_lvl, 2'h0, s_r.force_en};
      TPM_OFS_STATUS:   rd = {17'h00000, s_r.drv, ~s_r.sd_s2, s_r.car_dir[1],
                              2'h0, s_r.cut_flag, 1'b0, s_r.conc_flag};
      TPM_OFS_COUNT:    rd = 32'(s_r.car_cnt);
      default: begin
        rd  = '0;
        hit = 1'b0;
      end
    endcase
    s_nxt.ready = setup;
    s_nxt.err   = setup & ~hit;
    s_nxt.rdata = (setup && !pwrite) ? rd : '0;

    if (wr) begin
      unique case (paddr)
        TPM_OFS_CTRL:     s_nxt.ctrl   = pwdata & TPM_CTRL_MSK;
        TPM_OFS_CARRIER:  s_nxt.car_m  = pwdata[CNT_W-1:0];
        TPM_OFS_DEADTIME: s_nxt.dt_set = pwdata[DT_W-1:0];
        TPM_OFS_WU:       s_nxt.width[0] = pwdata[CNT_W-1:0];
        TPM_OFS_WV:       s_nxt.width[1] = pwdata[CNT_W-1:0];
        TPM_OFS_WW:       s_nxt.width[2] = pwdata[CNT_W-1:0];
        TPM_OFS_WU2:      s_nxt.width[3] = pwdata[CNT_W-1:0];
        TPM_OFS_WV2:      s_nxt.width[4] = pwdata[CNT_W-1:0];
        TPM_OFS_WW2:      s_nxt.width[5] = pwdata[CNT_W-1:0];
        TPM_OFS_PINS: begin
          s_nxt.force_en  = pwdata[5:0];
          s_nxt.force_lvl = pwdata[13:8];
          s_nxt.port_data = pwdata[21:16];
          s_nxt.port_dir  = pwdata[29:24];
        end
        TPM_OFS_STATUS: begin
          s_nxt.conc_flag = s_r.conc_flag & ~pwdata[2:0];
          s_nxt.cut_flag  = s_r.cut_flag & ~pwdata[4];
        end
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    // sticky flags set after the clear so a same-cycle event survives
    // flag overlap
    s_nxt.conc_flag = s_nxt.conc_flag | both;
    if (fen && !s_r.sd_s2) begin
      s_nxt.cut_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.ctrl    <= TPM_CTRL_RST;
      s_r.car_dir <= TPM_CAR_UP;
      s_r.sd_s1   <= 1'b1;
      s_r.sd_s2   <= 1'b1;
      s_r.oe_n    <= 6'h3F;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata        = s_r.rdata;
  assign pready        = s_r.ready;
  assign pslverr       = s_r.err;
  assign drive_out     = s_r.drv;
  assign drive_oe_n    = s_r.oe_n;
  assign carrier_pulse = s_r.pulse;
endmodule

// *** test/tpm_chk_properties.sv ***
// port checker for the three-phase pwm block
`timescale 1ns/10ps
module tpm_chk
  import tpm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shutdown_input_n,
  input wire logic [5:0]  drive_out,
  input wire logic [5:0]  drive_oe_n,
  input wire logic        carrier_pulse
);
  // ----------------------------------------------------------------
  // shadow of control and pin registers
  // ----------------------------------------------------------------
  logic [31:0] ctl_r;
  logic [31:0] pin_r;
  logic [3:0]  q_r;
  logic        wr_c;
  logic        st;
  logic [5:0]  act;
  assign wr_c = psel && penable && pready && pwrite && !pslverr;
  // settled: long enough after a write or a pin change for the pins to follow
  assign st   = q_r > 4'h7;
  assign act  = ctl_r[TPM_B_ACTH] ? drive_out : ~drive_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
      pin_r <= '0;
      q_r   <= '0;
    end else begin
      if (wr_c && paddr == TPM_OFS_CTRL) ctl_r <= pwdata & TPM_CTRL_MSK;
      if (wr_c && paddr == TPM_OFS_PINS) pin_r <= pwdata;
      if (wr_c || $changed(shutdown_input_n)) q_r <= '0;
      else if (q_r != 4'hF) q_r <= q_r + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  cut_hiz_a: assert property (
    st && ctl_r[TPM_B_FEN] && ctl_r[TPM_B_HIZ] && !shutdown_input_n |-> drive_oe_n == 6'h3F)
    else $error("cutoff did not float pins");
  cut_port_a: assert property (
    st && ctl_r[TPM_B_FEN] && !ctl_r[TPM_B_HIZ] && !shutdown_input_n
    |-> drive_oe_n == ~pin_r[29:24] && drive_out == pin_r[21:16])
    else $error("cutoff did not return pins to port");
  off_port_a: assert property (
    st && !ctl_r[TPM_B_FEN] |-> drive_oe_n == ~pin_r[29:24] && drive_out == pin_r[21:16])
    else $error("pins not under port control");
  pair_block_a: assert property (
    st && ctl_r[TPM_B_FEN] && ctl_r[TPM_B_CDIS] && shutdown_input_n
    |-> !((act[0] && act[1]) || (act[2] && act[3]) || (act[4] && act[5])))
    else $error("both pins of a pair active");
  pulse_single_a: assert property (
    carrier_pulse && ctl_r[10:8] != TPM_SRC_F1 |=> !carrier_pulse)
    else $error("carrier pulse longer than one cycle");
  idle_no_pulse_a: assert property (
    st && !ctl_r[TPM_B_RUN] |-> !carrier_pulse)
    else $error("carrier pulse while stopped");
endmodule

bind tpm_top tpm_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .shutdown_input_n(shutdown_input_n), .drive_out(drive_out),
  .drive_oe_n(drive_oe_n), .carrier_pulse(carrier_pulse));

// *** test/tpm_gate_model.sv ***
// gate driver stage model facing the six drive pins
`timescale 1ns/10ps
module tpm_gate_model (
  input  wire logic       pclk,
  input  wire logic       cut_req,
  input  wire logic [5:0] drive_out,
  input  wire logic [5:0] drive_oe_n,
  output logic            shutdown_input_n,
  output logic [5:0]      gate
);
  initial shutdown_input_n = 1'b1;
  always @(posedge pclk) shutdown_input_n <= !cut_req;
  assign gate = drive_out & ~drive_oe_n;
endmodule

// *** test/tb.sv ***
// self-checking testbench for the three-phase pwm block
`timescale 1ns/10ps
module tb;
  import tpm_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} tpm_note_type;
  logic         pclk, presetn, psel, penable, pwrite, subclock, cut_req;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, seed, rnd;
  logic [5:0]   drive_out, drive_oe_n, gate;
  logic [6:0]   obs;
  logic         pready, pslverr, sd_n, carrier_pulse;
  int           err_count, cmp_count, f, cnt;
  tpm_note_type notes[$];
  tpm_note_type nt;
  assign obs = {carrier_pulse, drive_out};
  always #12.5 pclk = ~pclk;
  // subclock period is exactly 26 clocks and toggles on falling pclk edges
  always #325 subclock = ~subclock;
  tpm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shutdown_input_n(sd_n), .subclock(subclock),
    .drive_out(drive_out), .drive_oe_n(drive_oe_n), .carrier_pulse(carrier_pulse));
  tpm_gate_model i_gate (.pclk(pclk), .cut_req(cut_req), .drive_out(drive_out),
    .drive_oe_n(drive_oe_n), .shutdown_input_n(sd_n), .gate(gate));
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    notes.push_back('{32'h0, 32'h0, 1'b0});
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    notes.push_back('{e, m, err});
    apb(1'b0, a, 32'h0);
  endtask
  // one completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk(prdata & nt.m, nt.d);
      chk({31'h0, pslverr}, {31'h0, nt.e});
    end
  end
  // the first pulse after a change is skipped, it may mix old and new settings
  task automatic mchk(input int k, input logic pol, input int eh, input int ep);
    int h;
    int p;
    for (int r = 0; r < 2; r++) begin
      h = 0;
      while (obs[k] === pol) @(posedge pclk);
      while (obs[k] !== pol) @(posedge pclk);
      while (obs[k] === pol) begin h++; @(posedge pclk); end
      p = h;
      while (obs[k] !== pol) begin p++; @(posedge pclk); end
    end
    chk(h, eh);
    chk(p, ep);
  endtask
  task automatic cfg(input logic [31:0] c, input int m, input int p, input int n);
    wr(TPM_OFS_CTRL, 32'h0);
    wr(TPM_OFS_CARRIER, m);
    wr(TPM_OFS_DEADTIME, p);
    wr(TPM_OFS_WU, n);
    wr(TPM_OFS_WV, n + 1);
    wr(TPM_OFS_WW, n + 2);
    wr(TPM_OFS_CTRL, c);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1500000;
    err_count++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, subclock, cut_req} = '0;
    paddr = '0;
    pwdata = '0;
    seed = 32'h7E5DB242;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rnd = $random(seed);
    rd(TPM_OFS_CTRL, TPM_CTRL_RST, 32'hFFFFFFFF, 1'b0);
    wr(TPM_OFS_CTRL, rnd);
    rd(TPM_OFS_CTRL, rnd & TPM_CTRL_MSK, 32'hFFFFFFFF, 1'b0);
    wr(TPM_OFS_PINS, rnd);
    rd(TPM_OFS_PINS, rnd & 32'h3F3F3F3F, 32'hFFFFFFFF, 1'b0);
    wr(TPM_OFS_PINS, 32'h0);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      f = (s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 8 : 32;
      cfg(32'h0010002B | (s << 8), 3, 0, 1);
      mchk(0, 1'b1, f, 4 * f);
      mchk(2, 1'b1, 2 * f, 4 * f);
      mchk(4, 1'b1, 3 * f, 4 * f);
      mchk(1, 1'b1, 3 * f, 4 * f);
      mchk(6, 1'b1, 1, 4 * f);
    end
    cfg(32'h0010042B, 3, 0, 1);
    mchk(0, 1'b1, 832, 3328);
    $display("test sawtooth sources done");
    wr(TPM_OFS_WU2, 32'h1);
    cfg(32'h00100029, 3, 0, 2);
    mchk(0, 1'b1, 4, 8);
    wr(TPM_OFS_CTRL, 32'h0010002D);
    mchk(0, 1'b1, 3, 8);
    $display("test triangular done");
    cfg(32'h0010001B, 7, 2, 4);
    mchk(0, 1'b1, 2, 8);
    mchk(1, 1'b1, 2, 8);
    mchk(3, 1'b1, 1, 8);
    cfg(32'h00100023, 3, 0, 1);
    mchk(0, 1'b0, 1, 4);
    $display("test dead time and level done");
    cfg(32'h0013002B, 3, 0, 1);
    mchk(6, 1'b1, 1, 12);
    cfg(32'h001F012B, 3, 0, 1);
    mchk(6, 1'b1, 1, 120);
    $display("test pulse interval done");
    cfg(32'h0010002B, 3, 0, 1);
    wr(TPM_OFS_PINS, 32'h00000101);
    repeat (20) @(posedge pclk);
    cnt = 0;
    repeat (16) begin
      @(posedge pclk);
      if (drive_out[0] === 1'b1) cnt++;
    end
    chk(cnt, 16);
    wr(TPM_OFS_PINS, 32'h00000303);
    repeat (20) @(posedge pclk);
    rd(TPM_OFS_STATUS, 32'h1, 32'h1, 1'b0);
    wr(TPM_OFS_PINS, 32'h0);
    $display("test force and detect done");
    cfg(32'h0010006B, 3, 0, 1);
    cut_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(drive_oe_n, 6'h3F);
    chk(gate, 6'h00);
    rd(TPM_OFS_STATUS, 32'h110, 32'h7F10, 1'b0);
    rnd = $random(seed);
    wr(TPM_OFS_PINS, 32'h3F000000 | {rnd[5:0], 16'h0});
    wr(TPM_OFS_CTRL, 32'h0010002B);
    repeat (8) @(posedge pclk);
    chk(drive_out, rnd[5:0]);
    chk(drive_oe_n, 6'h00);
    wr(TPM_OFS_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    chk(drive_out, rnd[5:0]);
    cut_req <= 1'b0;
    repeat (8) @(posedge pclk);
    $display("test cutoff done");
    give_verdict();
  end
endmodule
